// file: core/fip_pkg.sv
// constants for the flash interrupt, protection and ecc status register bank
// assumes an apb slave with 32-bit data; each register index takes one word
package fip_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_INT_STAT = 16'hf241;
    localparam logic [15:0] IDX_FIRST_BLK = 16'hf24c;
    localparam logic [15:0] IDX_LAST_BLK = 16'hf24d;
    localparam logic [15:0] IDX_PROT = 16'hf24e;
    localparam logic [15:0] IDX_ECC = 16'hff00;
    localparam logic [15:0] IDX_EVT_STAT = 16'hf260;
    localparam logic [15:0] IDX_EVT_EN = 16'hf261;
    localparam logic [15:0] IDX_EVT_CLR = 16'hf262;
    localparam int ADDR_W = 18;
    localparam int IDX_LSB = 2;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // interrupt status layout
    localparam int INT_BIT = 15;
    localparam int LOAD_BIT = 7;
    localparam int PROG_BIT = 6;
    localparam int ERASE_BIT = 5;
    localparam int RSTD_BIT = 4;
    localparam int EVT_W = 4;
    localparam logic [15:0] INT_STAT_COLD = 16'h8080;
    // event vector positions inside the four-bit event registers
    localparam int EV_RSTD = 0;
    localparam int EV_ERASE = 1;
    localparam int EV_PROG = 2;
    localparam int EV_LOAD = 3;
    // block protection
    localparam int BLK_W_DEF = 10;
    localparam logic [1:0] LK_UNLOCKED = 2'h0;
    localparam logic [1:0] LK_LOCKED = 2'h1;
    localparam logic [1:0] LK_TIGHT = 2'h2;
    localparam logic [1:0] OP_UNLOCK = 2'h0;
    localparam logic [1:0] OP_LOCK = 2'h1;
    localparam logic [1:0] OP_TIGHT = 2'h2;
    localparam int PROT_UNLK_BIT = 2;
    localparam int PROT_LOCK_BIT = 1;
    localparam int PROT_TIGHT_BIT = 0;
    // ecc result encoding and packing
    localparam int SECTORS = 4;
    localparam int SECT_W = 4;
    localparam int MAIN_LSB = 2;
    localparam int SPARE_LSB = 0;
    localparam logic [1:0] ECC_NONE = 2'h0;
    localparam logic [1:0] ECC_ONE = 2'h1;
    localparam logic [1:0] ECC_TWO = 2'h2;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_ZERO = 2'h0;
endpackage

// file: core/fip_regs.sv
// interrupt status, block protection and ecc status registers of the flash
// assumes completion pulses, ecc counts and reset levels come from logic on clk_sys_in
// Behaviour
// - load done flag sets on load command, buffer load or boot load completion.
// - program done flag sets when any program operation completes.
// - erase done flag sets when any erase operation completes.
// - reset done flag sets on reset command completion or warm reset release.
// - load, program, erase flags clear on host zero write or warm or hot reset; cold reset clears program and erase but sets load.
// - reset done flag clears by host zero write or cold reset, never by warm or hot reset.
// - start block register holds ten-bit block number; host writes it before lock commands.
// - end block location is reserved and has no function.
// - protection status shows unlocked, locked, locked-tight in bits two, one, zero.
// - ecc detects one- and two-bit errors, corrects one-bit errors only.
// - ecc field codes: 00 none, 01 correctable, 10 uncorrectable, 11 reserved.
// - ecc status packs four sectors, main pair above spare pair per nibble.
// - ecc fields update on each load check and during boot loading.
// - main and spare area of each sector each get their own result.
// - master interrupt bit sets when any completion flag sets and drives the pin.
// - completion flags sit at bits seven, six, five and four of interrupt status.
`timescale 1ns/1ps
module fip_regs import fip_pkg::*; #(
    parameter int BLK_W = BLK_W_DEF
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    output logic [DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic load_done_in,
    input wire logic boot_done_in,
    input wire logic prog_done_in,
    input wire logic erase_done_in,
    input wire logic rst_cmd_done_in,
    input wire logic warm_rst_in,
    input wire logic hot_rst_in,
    input wire logic lock_cmd_in,
    input wire logic [1:0] lock_op_in,
    input wire logic [BLK_W-1:0] flash_block_select_in,
    input wire logic ecc_valid_in,
    input wire logic [2*SECTORS-1:0] ecc_main_cnt_in,
    input wire logic [2*SECTORS-1:0] ecc_spare_cnt_in,
    output logic [BLK_W-1:0] first_block_out,
    output logic int_pin_out,
    output logic irq_out
);
    localparam int NBLK = 1 << BLK_W;

    typedef struct packed {
        logic [NBLK-1:0][1:0] lock_state;
        logic [REG_W-1:0] int_stat;
        logic [BLK_W-1:0] first_blk;
        logic [REG_W-1:0] ecc_stat;
        logic [EVT_W-1:0] evt_stat;
        logic [EVT_W-1:0] evt_en;
        logic warm_q;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic int_pin;
        logic irq;
    } fip_state_t;

    fip_state_t state_reg;
    fip_state_t state_next;

    // error count to status code; three or more errors cannot be seen, so they read as two
    function automatic logic [1:0] ecc_code(input logic [1:0] cnt);
        logic [1:0] code;
        code = ECC_TWO;
        if (cnt == CNT_ZERO) begin
            code = ECC_NONE;
        end else if (cnt == CNT_ONE) begin
            code = ECC_ONE;
        end
        return code;
    endfunction

    logic [15:0] setup_idx;
    logic [15:0] acc_idx;
    logic setup_phase;
    logic wr_done;
    logic any_rst;
    logic warm_release;
    logic [EVT_W-1:0] done_ev;
    logic [EVT_W-1:0] new_flags;
    logic [1:0] sel_state;
    logic [1:0] tgt_state;
    logic [REG_W-1:0] rd_word;
    logic rd_hit;

    always_comb begin
        state_next = state_reg;
        setup_phase = psel_in && !penable_in;
        wr_done = psel_in && penable_in && state_reg.pready && pwrite_in;
        setup_idx = paddr_in[ADDR_W-1:IDX_LSB];
        acc_idx = paddr_in[ADDR_W-1:IDX_LSB];
        any_rst = warm_rst_in || hot_rst_in;
        warm_release = state_reg.warm_q && !warm_rst_in;
        state_next.warm_q = warm_rst_in;

        // completion events in event-vector order
        done_ev = '0;
        done_ev[EV_LOAD] = load_done_in || boot_done_in;
        done_ev[EV_PROG] = prog_done_in;
        done_ev[EV_ERASE] = erase_done_in;
        done_ev[EV_RSTD] = rst_cmd_done_in || warm_release;

        // host writes to interrupt status: zero clears, one is ignored
        if (wr_done && acc_idx == IDX_INT_STAT) begin
            if (!pwdata_in[LOAD_BIT]) begin
                state_next.int_stat[LOAD_BIT] = 1'b0;
            end
            if (!pwdata_in[PROG_BIT]) begin
                state_next.int_stat[PROG_BIT] = 1'b0;
            end
            if (!pwdata_in[ERASE_BIT]) begin
                state_next.int_stat[ERASE_BIT] = 1'b0;
            end
            if (!pwdata_in[RSTD_BIT]) begin
                state_next.int_stat[RSTD_BIT] = 1'b0;
            end
            if (!pwdata_in[INT_BIT]) begin
                state_next.int_stat[INT_BIT] = 1'b0;
            end
        end

        // warm and hot resets clear three flags and the master bit, not reset done
        if (any_rst) begin
            state_next.int_stat[LOAD_BIT] = 1'b0;
            state_next.int_stat[PROG_BIT] = 1'b0;
            state_next.int_stat[ERASE_BIT] = 1'b0;
            state_next.int_stat[INT_BIT] = 1'b0;
        end

        // events set after the clears so a set wins over a host zero write; a warm or hot reset wins except for reset done
        new_flags = done_ev & ~{state_reg.int_stat[LOAD_BIT], state_reg.int_stat[PROG_BIT],
                                state_reg.int_stat[ERASE_BIT], state_reg.int_stat[RSTD_BIT]};
        if (done_ev[EV_LOAD] && !any_rst) begin
            state_next.int_stat[LOAD_BIT] = 1'b1;
        end
        if (done_ev[EV_PROG] && !any_rst) begin
            state_next.int_stat[PROG_BIT] = 1'b1;
        end
        if (done_ev[EV_ERASE] && !any_rst) begin
            state_next.int_stat[ERASE_BIT] = 1'b1;
        end
        if (done_ev[EV_RSTD]) begin
            state_next.int_stat[RSTD_BIT] = 1'b1;
        end
        if ((|new_flags || (|done_ev && !state_reg.int_stat[INT_BIT])) && !(any_rst && !done_ev[EV_RSTD])) begin
            state_next.int_stat[INT_BIT] = 1'b1;
        end
        state_next.int_pin = state_next.int_stat[INT_BIT];

        // start block register; only the block number bits store
        if (wr_done && acc_idx == IDX_FIRST_BLK) begin
            state_next.first_blk = pwdata_in[BLK_W-1:0];
        end

        // lock commands act on the block held in the start block register
        tgt_state = state_reg.lock_state[state_reg.first_blk];
        if (lock_cmd_in && tgt_state != LK_TIGHT) begin
            case (lock_op_in)
                OP_UNLOCK: state_next.lock_state[state_reg.first_blk] = LK_UNLOCKED;
                OP_LOCK: state_next.lock_state[state_reg.first_blk] = LK_LOCKED;
                OP_TIGHT: state_next.lock_state[state_reg.first_blk] = LK_TIGHT;
                default: state_next.lock_state[state_reg.first_blk] = tgt_state;
            endcase
        end

        // ecc results from each load check or boot load check
        if (ecc_valid_in) begin
            for (int s = 0; s < SECTORS; s++) begin
                state_next.ecc_stat[s*SECT_W+MAIN_LSB +: 2] = ecc_code(ecc_main_cnt_in[2*s +: 2]);
                state_next.ecc_stat[s*SECT_W+SPARE_LSB +: 2] = ecc_code(ecc_spare_cnt_in[2*s +: 2]);
            end
        end

        // sticky event status, write-one clear, enable gating
        if (wr_done && acc_idx == IDX_EVT_EN) begin
            state_next.evt_en = pwdata_in[EVT_W-1:0];
        end
        if (wr_done && acc_idx == IDX_EVT_CLR) begin
            state_next.evt_stat = state_reg.evt_stat & ~pwdata_in[EVT_W-1:0];
        end
        state_next.evt_stat = state_next.evt_stat | done_ev;
        state_next.irq = |(state_next.evt_stat & state_next.evt_en);

        // read decode in the setup cycle; answer stands in the access cycle
        sel_state = state_reg.lock_state[flash_block_select_in];
        rd_word = '0;
        rd_hit = 1'b1;
        case (setup_idx)
            IDX_INT_STAT: rd_word = state_reg.int_stat;
            IDX_FIRST_BLK: rd_word[BLK_W-1:0] = state_reg.first_blk;
            IDX_LAST_BLK: rd_word = '0;
            IDX_PROT: begin
                rd_word[PROT_UNLK_BIT] = (sel_state == LK_UNLOCKED);
                rd_word[PROT_LOCK_BIT] = (sel_state == LK_LOCKED);
                rd_word[PROT_TIGHT_BIT] = (sel_state == LK_TIGHT);
            end
            IDX_ECC: rd_word = state_reg.ecc_stat;
            IDX_EVT_STAT: rd_word[EVT_W-1:0] = state_reg.evt_stat;
            IDX_EVT_EN: rd_word[EVT_W-1:0] = state_reg.evt_en;
            IDX_EVT_CLR: rd_word = '0;
            default: rd_hit = 1'b0;
        endcase
        state_next.pready = setup_phase;
        if (setup_phase) begin
            state_next.prdata = {{(DATA_W-REG_W){1'b0}}, rd_word};
            state_next.pslverr = !rd_hit;
        end else if (!psel_in) begin
            state_next.prdata = '0;
            state_next.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state_reg <= '0;
            state_reg.int_stat <= INT_STAT_COLD;
            for (int b = 0; b < NBLK; b++) begin
                state_reg.lock_state[b] <= LK_LOCKED;
            end
            state_reg.int_pin <= INT_STAT_COLD[INT_BIT];
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata_out = state_reg.prdata;
    assign pready_out = state_reg.pready;
    assign pslverr_out = state_reg.pslverr;
    assign first_block_out = state_reg.first_blk;
    assign int_pin_out = state_reg.int_pin;
    assign irq_out = state_reg.irq;
endmodule

// file: testbench/fip_host_model.sv
// apb master standing in for the host processor
// assumes one transfer at a time; address and write data inverted when released
`timescale 1ns/1ps
module fip_host_model import fip_pkg::*; (
    input wire logic clk_sys_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [ADDR_W-1:0] paddr_out,
    output logic [DATA_W-1:0] pwdata_out,
    input wire logic [DATA_W-1:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = '0;
        pwdata_out = '0;
    end
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic hung);
        @(posedge clk_sys_in);
        psel_out <= 1'b1;
        pwrite_out <= wr;
        paddr_out <= {idx, 2'h0};
        pwdata_out <= wd;
        @(posedge clk_sys_in);
        penable_out <= 1'b1;
        hung = 1'b1;
        for (int n = 0; n < 16 && hung; n++) begin
            @(posedge clk_sys_in);
            if (pready_in === 1'b1) begin
                hung = 1'b0;
                rd = prdata_in;
                err = pslverr_in;
            end
        end
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        paddr_out <= ~{idx, 2'h0};
        pwdata_out <= ~wd;
    endtask
endmodule

// file: testbench/fip_regs_properties.sv
// assertions on the status register bank ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module fip_regs_properties import fip_pkg::*; #(
    parameter int BLK_W = BLK_W_DEF
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    input wire logic [DATA_W-1:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic load_done_in,
    input wire logic boot_done_in,
    input wire logic prog_done_in,
    input wire logic erase_done_in,
    input wire logic rst_cmd_done_in,
    input wire logic warm_rst_in,
    input wire logic hot_rst_in,
    input wire logic [BLK_W-1:0] first_block_out,
    input wire logic int_pin_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    logic quiet;
    logic any_ev;
    assign quiet = !warm_rst_in && !hot_rst_in;
    assign any_ev = load_done_in || boot_done_in || prog_done_in || erase_done_in || rst_cmd_done_in;
    sequence s_rd(logic [15:0] i);
        psel_in && !penable_in && !pwrite_in && paddr_in[17:2] == i;
    endsequence
    sequence s_wr(logic [15:0] i);
        psel_in && penable_in && pready_out && pwrite_in && paddr_in[17:2] == i;
    endsequence
    AST_READY: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready in access cycle");
    AST_LOAD_INT: assert property ((load_done_in || boot_done_in) && quiet |=> int_pin_out)
        else $error("load completion missed interrupt");
    AST_PROG_INT: assert property (prog_done_in && quiet |=> int_pin_out)
        else $error("program completion missed interrupt");
    AST_ERASE_INT: assert property (erase_done_in && quiet |=> int_pin_out)
        else $error("erase completion missed interrupt");
    AST_WARM_REL: assert property ($fell(warm_rst_in) && !hot_rst_in |=> int_pin_out)
        else $error("warm release missed interrupt");
    AST_RST_CLR: assert property (!quiet && !rst_cmd_done_in |=> !int_pin_out)
        else $error("interrupt kept during reset");
    AST_INT_CAUSE: assert property ($rose(int_pin_out) |-> $past(any_ev) || $past(warm_rst_in, 2))
        else $error("interrupt rose without cause");
    AST_PROT: assert property (s_rd(IDX_PROT) |=> prdata_out[15:3] == 0 && $onehot(prdata_out[2:0]))
        else $error("bad protection status");
    AST_ECC_CODE: assert property (s_rd(IDX_ECC) |=> (prdata_out & (prdata_out >> 1) & 32'h5555) == 0)
        else $error("reserved ecc code");
    AST_FIRST_BLK: assert property (s_wr(IDX_FIRST_BLK) |=> first_block_out == BLK_W'($past(pwdata_in)))
        else $error("start block not stored");
    AST_RSVD: assert property (s_rd(IDX_LAST_BLK) |=> prdata_out == 0 && !pslverr_out)
        else $error("reserved location not zero");
endmodule
bind fip_regs fip_regs_properties #(.BLK_W(BLK_W)) chk_u (.*);

// file: testbench/flash_irq_protect_ecc_status_test.sv
// self-checking bench for the status register bank
// assumes the host model issues apb transfers one at a time
`timescale 1ns/1ps
module flash_irq_protect_ecc_status_test import fip_pkg::*; ;
    logic clk_sys_in = 0, nrst_in = 0, warm = 0, hot = 0, lk = 0, ecc_v = 0, perr;
    logic [4:0] ev = 0;
    logic [1:0] lk_op = 0;
    logic [9:0] fbs = 0, fb;
    logic [7:0] em = 0, es = 0;
    logic psel, pen, pwr, rdy, err, int_pin, irq;
    logic [ADDR_W-1:0] pa;
    logic [31:0] pwd, prd, d;
    int n_errors = 0, total_checks = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    fip_host_model host_u (.clk_sys_in(clk_sys_in), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
        .paddr_out(pa), .pwdata_out(pwd), .prdata_in(prd), .pready_in(rdy), .pslverr_in(err));
    fip_regs #(.BLK_W(10)) dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(err), .load_done_in(ev[0]), .boot_done_in(ev[1]),
        .prog_done_in(ev[2]), .erase_done_in(ev[3]), .rst_cmd_done_in(ev[4]), .warm_rst_in(warm),
        .hot_rst_in(hot), .lock_cmd_in(lk), .lock_op_in(lk_op), .flash_block_select_in(fbs),
        .ecc_valid_in(ecc_v), .ecc_main_cnt_in(em), .ecc_spare_cnt_in(es), .first_block_out(fb),
        .int_pin_out(int_pin), .irq_out(irq));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rw(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        logic hung;
        host_u.xfer(wr, idx, wd, d, perr, hung);
        if (hung) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        rw(1'b0, idx, 32'h0);
        chk(d, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_sys_in) ev <= 5'h1 << i;
        @(posedge clk_sys_in) ev <= 5'h0;
    endtask
    function automatic logic [1:0] enc(input logic [1:0] c);
        return c == 2'h0 ? 2'h0 : (c == 2'h1 ? 2'h1 : 2'h2);
    endfunction
    task automatic t_defaults();
        rd_chk(IDX_INT_STAT, 32'h8080);
        rd_chk(IDX_FIRST_BLK, 32'h0);
        rd_chk(IDX_PROT, 32'h2);
        rd_chk(IDX_ECC, 32'h0);
        rd_chk(IDX_LAST_BLK, 32'h0);
    endtask
    task automatic t_flags();
        int bp [5] = '{LOAD_BIT, LOAD_BIT, PROG_BIT, ERASE_BIT, RSTD_BIT};
        for (int i = 0; i < 5; i++) begin
            rw(1'b1, IDX_INT_STAT, 32'h0);
            rd_chk(IDX_INT_STAT, 32'h0);
            pulse(i);
            rd_chk(IDX_INT_STAT, 32'h8000 | (32'h1 << bp[i]));
            chk(32'(int_pin), 32'h1);
            rw(1'b1, IDX_INT_STAT, 32'hffff);
            rd_chk(IDX_INT_STAT, 32'h8000 | (32'h1 << bp[i]));
        end
    endtask
    task automatic t_resets();
        rw(1'b1, IDX_INT_STAT, 32'h0);
        pulse(0);
        @(posedge clk_sys_in) warm <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        warm <= 1'b0;
        rd_chk(IDX_INT_STAT, 32'h8010);
        pulse(2);
        @(posedge clk_sys_in) hot <= 1'b1;
        @(posedge clk_sys_in) hot <= 1'b0;
        rd_chk(IDX_INT_STAT, 32'h0010);
    endtask
    task automatic t_block();
        logic [1:0] ops [4] = '{OP_UNLOCK, OP_LOCK, OP_TIGHT, OP_UNLOCK};
        logic [31:0] exp [4] = '{32'h4, 32'h2, 32'h1, 32'h1};
        rw(1'b1, IDX_FIRST_BLK, 32'hffff);
        rd_chk(IDX_FIRST_BLK, 32'h3ff);
        rw(1'b1, IDX_FIRST_BLK, 32'h5);
        @(negedge clk_sys_in) chk(32'(fb), 32'h5);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in) {lk, lk_op, fbs} <= {1'b1, ops[i], 10'h5};
            @(posedge clk_sys_in) lk <= 1'b0;
            rd_chk(IDX_PROT, exp[i]);
            if (i == 0) begin
                @(posedge clk_sys_in) fbs <= 10'h6;
                rd_chk(IDX_PROT, 32'h2);
                @(posedge clk_sys_in) fbs <= 10'h5;
            end
        end
    endtask
    task automatic t_ecc();
        logic [31:0] e;
        logic [7:0] m [2] = '{8'he4, 8'h1b};
        for (int k = 0; k < 2; k++) begin
            e = 32'h0;
            for (int n = 0; n < SECTORS; n++)
                e[4*n +: 4] = {enc(m[k][2*n +: 2]), enc(m[1-k][2*n +: 2])};
            @(posedge clk_sys_in) {ecc_v, em, es} <= {1'b1, m[k], m[1-k]};
            @(posedge clk_sys_in) ecc_v <= 1'b0;
            rd_chk(IDX_ECC, e);
        end
    endtask
    task automatic t_evt();
        rw(1'b1, IDX_EVT_CLR, 32'hf);
        rw(1'b1, IDX_EVT_EN, 32'hf);
        pulse(3);
        @(negedge clk_sys_in) chk(32'(irq), 32'h1);
        rd_chk(IDX_EVT_STAT, 32'h1 << EV_ERASE);
        rw(1'b1, IDX_EVT_EN, 32'h0);
        @(negedge clk_sys_in) chk(32'(irq), 32'h0);
        rw(1'b1, IDX_EVT_EN, 32'hf);
        rw(1'b1, IDX_EVT_CLR, 32'h1 << EV_ERASE);
        rd_chk(IDX_EVT_STAT, 32'h0);
        @(negedge clk_sys_in) chk(32'(irq), 32'h0);
        rd_chk(16'h0123, 32'h0);
        chk(32'(perr), 32'h1);
    endtask
    task automatic t_cold();
        rw(1'b1, IDX_FIRST_BLK, 32'h7);
        @(posedge clk_sys_in) nrst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        rd_chk(IDX_INT_STAT, 32'h8080);
        rd_chk(IDX_FIRST_BLK, 32'h0);
        rd_chk(IDX_PROT, 32'h2);
        @(negedge clk_sys_in) chk(32'(int_pin), 32'h1);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        t_defaults();
        t_flags();
        t_resets();
        t_block();
        t_ecc();
        t_evt();
        t_cold();
        wrap_up();
    end
endmodule
